// [dv/pdb_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdb_params.svh"

module pdb_asserts (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Bus signals
	input wire logic [`PDB_ADDR_W-1:0] word_address_lines,
	input wire logic [`PDB_LANES-1:0] byte_lane_strobes,
	input wire logic privilege_select,
	input wire logic read_write_select,
	input wire logic bus_lock,
	input wire logic [`PDB_WORD_W-1:0] dev_data,
	input wire logic dev_data_oe,
	input wire logic rsp_data_oe,
	input wire pdb_pkg::pdb_reply_e reply_code
);
	localparam pdb_pkg::pdb_reply_e W = pdb_pkg::PDB_RPL_WAIT;
	localparam pdb_pkg::pdb_reply_e F = pdb_pkg::PDB_RPL_FAULT;
	localparam pdb_pkg::pdb_reply_e S = pdb_pkg::PDB_RPL_SUCCESS;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	// ----------------------------------------------------------------
	// Bus checks
	// ----------------------------------------------------------------
	chk_no_bus_clash: assert property (!(dev_data_oe && rsp_data_oe))
		else $error("both ends drive the data lines");
	chk_addr_hold_wait: assert property (reply_code == W |=> $stable(word_address_lines)
		&& $stable(byte_lane_strobes) && $stable(read_write_select) && $stable(privilege_select))
		else $error("address phase changed during a wait");
	chk_wdata_wait_hold: assert property (dev_data_oe && reply_code == W |=>
		dev_data_oe && $stable(dev_data)) else $error("write data not repeated on wait");
	chk_no_data_wait: assert property (!dev_data_oe && reply_code == W |=> !dev_data_oe)
		else $error("write data driven while previous reply waits");
	// A fault on the previous transfer still lets the write drive its data
	chk_wdata_after_reply: assert property (byte_lane_strobes != 4'h0 && !read_write_select
		&& (reply_code == S || reply_code == F) |=> dev_data_oe)
		else $error("write data missing after previous reply");
	chk_lock_on_read: assert property ($rose(bus_lock) |->
		read_write_select && byte_lane_strobes != 4'h0) else $error("lock not raised on a read");
	chk_lock_thru_wait: assert property (bus_lock && reply_code == W |=> bus_lock)
		else $error("lock dropped during a wait");
	chk_fault_next_ignored: assert property (reply_code == F |=>
		reply_code == pdb_pkg::PDB_RPL_NONE) else $error("transfer after fault answered");
	chk_fault_then_null: assert property (reply_code == F |-> ##2 (byte_lane_strobes == 4'h0)[*4])
		else $error("real transfer issued while halted");

	cov_fault: cover property (reply_code == F);
	cov_lock: cover property ($rose(bus_lock));
	cov_write_wait: cover property (dev_data_oe && reply_code == W);
endmodule

`default_nettype wire

// [dv/pdb_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdb_params.svh"

module pdb_tb;
	localparam pdb_pkg::pdb_size_e SZ_B = pdb_pkg::PDB_SZ_BYTE;
	localparam pdb_pkg::pdb_size_e SZ_H = pdb_pkg::PDB_SZ_HALF;
	localparam pdb_pkg::pdb_size_e SZ_W = pdb_pkg::PDB_SZ_WORD;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic req_xchg_i = 1'b0;
	logic req_signed_i = 1'b0;
	logic req_super_i = 1'b0;
	pdb_pkg::pdb_size_e req_size_i = SZ_W;
	logic [31:0] req_addr_i = 32'h0;
	logic [31:0] req_wdata_i = 32'h0;
	logic resume_i = 1'b0;
	logic [3:0] wait_cycles_i = 4'h0;
	logic fault_inject_i = 1'b0;
	logic req_ready_o, rd_valid_o, wr_done_o, fault_o, halted_o;
	logic lock_held_o, rsp_wr_done_o;
	int lock_cnt = 0;
	int rsp_wr_cnt = 0;
	logic [31:0] rd_data_o, fault_addr_o;
	logic [31:0] mon_exp = 32'h0;
	logic mon_on = 1'b0;
	int err_count = 0;
	int check_count = 0;
	int ev_cnt = 0;
	int ev_exp = 0;

	pdb_if bus_if();
	pdb_dev pdb_dev_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_xchg_i(req_xchg_i),
		.req_signed_i(req_signed_i), .req_size_i(req_size_i), .req_super_i(req_super_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .wr_done_o(wr_done_o), .fault_o(fault_o),
		.fault_addr_o(fault_addr_o), .halted_o(halted_o), .resume_i(resume_i), .bus(bus_if));
	pdb_rsp pdb_rsp_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wait_cycles_i(wait_cycles_i),
		.fault_inject_i(fault_inject_i), .lock_held_o(lock_held_o),
		.wr_done_o(rsp_wr_done_o), .bus(bus_if));
	pdb_asserts pdb_asserts_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.word_address_lines(bus_if.word_address_lines),
		.byte_lane_strobes(bus_if.byte_lane_strobes),
		.privilege_select(bus_if.privilege_select), .read_write_select(bus_if.read_write_select),
		.bus_lock(bus_if.bus_lock), .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe),
		.rsp_data_oe(bus_if.rsp_data_oe), .reply_code(bus_if.reply_code));

	always #12.5 mclk_i = ~mclk_i;

	// ----------------------------------------------------------------
	// Completion counter and write data monitor
	// ----------------------------------------------------------------
	always @(negedge mclk_i) begin
		if (rd_valid_o === 1'b1 || wr_done_o === 1'b1 || fault_o === 1'b1)
			ev_cnt++;
		// Lock cycles seen by the far side, and stores the responder really made
		if (lock_held_o === 1'b1)
			lock_cnt++;
		if (rsp_wr_done_o === 1'b1)
			rsp_wr_cnt++;
		if (mon_on && bus_if.dev_data_oe === 1'b1)
			chk(bus_if.bidir_data_lines, mon_exp);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic issue(input logic w, input logic x, input logic s,
		input pdb_pkg::pdb_size_e sz, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge mclk_i);
		req_write_i = w;
		req_xchg_i = x;
		req_signed_i = s;
		req_size_i = sz;
		req_addr_i = a;
		req_wdata_i = d;
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && n < 100) begin
			@(negedge mclk_i);
			n++;
		end
		chk({31'h0, req_ready_o}, 32'h1);
		@(negedge mclk_i);
		req_valid_i = 1'b0;
	endtask

	// Waits for completions; bounded so a lost answer shows as a mismatch
	task automatic settle(input int add);
		int n;
		n = 0;
		ev_exp += add;
		while (ev_cnt < ev_exp && n < 300) begin
			@(negedge mclk_i);
			n++;
		end
		chk(32'(ev_cnt), 32'(ev_exp));
	endtask

	task automatic rd(input logic s, input pdb_pkg::pdb_size_e sz, input logic [31:0] a,
		input logic [31:0] exp);
		issue(1'b0, 1'b0, s, sz, a, 32'h0);
		settle(1);
		chk(rd_data_o, exp);
	endtask

	// Waits out the window in which only null transfers may follow a fault
	task automatic recover();
		repeat (8) @(negedge mclk_i);
		chk({31'h0, halted_o}, 32'h1);
		resume_i = 1'b1;
		@(negedge mclk_i);
		resume_i = 1'b0;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(negedge mclk_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		issue(1'b1, 1'b0, 1'b0, SZ_W, 32'h4, 32'hcafe0123);
		settle(1);
		rd(1'b0, SZ_W, 32'h4, 32'hcafe0123);
		for (int i = 0; i < 4; i++) begin
			mon_exp = {4{8'h81 + 8'(8'h11 * i)}};
			mon_on = 1'b1;
			issue(1'b1, 1'b0, 1'b0, SZ_B, 32'h8 + 32'(i), {24'h0, mon_exp[7:0]});
			settle(1);
			mon_on = 1'b0;
		end
		rd(1'b0, SZ_W, 32'h8, 32'hb4a39281);
		rd(1'b1, SZ_B, 32'hb, 32'hffffffb4);
		rd(1'b0, SZ_B, 32'ha, 32'h000000a3);
		wait_cycles_i = 4'h2;
		mon_exp = 32'h80018001;
		mon_on = 1'b1;
		issue(1'b1, 1'b0, 1'b0, SZ_H, 32'he, 32'h8001);
		settle(1);
		mon_on = 1'b0;
		rd(1'b1, SZ_H, 32'he, 32'hffff8001);
		rd(1'b0, SZ_H, 32'ha, 32'h0000b4a3);
		wait_cycles_i = 4'h1;
		issue(1'b1, 1'b0, 1'b0, SZ_W, 32'h14, 32'h13579bdf);
		issue(1'b0, 1'b0, 1'b0, SZ_W, 32'h14, 32'h0);
		settle(2);
		chk(rd_data_o, 32'h13579bdf);
		issue(1'b0, 1'b1, 1'b0, SZ_W, 32'h4, 32'h2468ace0);
		settle(2);
		chk(rd_data_o, 32'hcafe0123);
		chk(32'(lock_cnt), 32'h3);
		rd(1'b0, SZ_W, 32'h4, 32'h2468ace0);
		wait_cycles_i = 4'h0;
		fault_inject_i = 1'b1;
		issue(1'b0, 1'b0, 1'b0, SZ_W, 32'h10, 32'h0);
		settle(1);
		fault_inject_i = 1'b0;
		chk(fault_addr_o, 32'h10);
		recover();
		rd(1'b0, SZ_W, 32'h4, 32'h2468ace0);
		// Faulted exchange read: the locked write still drives data but is dropped
		fault_inject_i = 1'b1;
		issue(1'b0, 1'b1, 1'b0, SZ_W, 32'h4, 32'h5a5a5a5a);
		settle(1);
		fault_inject_i = 1'b0;
		chk(fault_addr_o, 32'h4);
		chk(32'(lock_cnt), 32'h5);
		recover();
		rd(1'b0, SZ_W, 32'h4, 32'h2468ace0);
		chk(32'(rsp_wr_cnt), 32'h8);
		results();
	end

	// Tests take well under 2000 cycles; four times that means a hang
	initial begin
		#200000;
		err_count++;
		results();
	end
endmodule

`default_nettype wire

// [verilog/pdb_dev.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdb_params.svh"

module pdb_dev (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Load and store requests
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic req_xchg_i,
	input wire logic req_signed_i,
	input wire pdb_pkg::pdb_size_e req_size_i,
	input wire logic req_super_i,
	input wire logic [`PDB_WORD_W-1:0] req_addr_i,
	input wire logic [`PDB_WORD_W-1:0] req_wdata_i,
	// Completions
	output logic rd_valid_o,
	output logic [`PDB_WORD_W-1:0] rd_data_o,
	output logic wr_done_o,
	// Exception handling
	output logic fault_o,
	output logic [`PDB_WORD_W-1:0] fault_addr_o,
	output logic halted_o,
	input wire logic resume_i,
	// Data bus
	pdb_if.dev bus
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [`PDB_LANES-1:0] lane_mask(input pdb_pkg::pdb_size_e sz,
		input logic [`PDB_OFF_W-1:0] off);
		unique case (sz)
			pdb_pkg::PDB_SZ_BYTE: lane_mask = 4'h1 << off;
			pdb_pkg::PDB_SZ_HALF: lane_mask = off[1] ? 4'hc : 4'h3;
			default: lane_mask = 4'hf;
		endcase
	endfunction

	function automatic logic [`PDB_WORD_W-1:0] replicate(input pdb_pkg::pdb_size_e sz,
		input logic [`PDB_WORD_W-1:0] d);
		unique case (sz)
			pdb_pkg::PDB_SZ_BYTE: replicate = {4{d[7:0]}};
			pdb_pkg::PDB_SZ_HALF: replicate = {2{d[15:0]}};
			default: replicate = d;
		endcase
	endfunction

	function automatic logic [`PDB_WORD_W-1:0] extract(input pdb_pkg::pdb_size_e sz,
		input logic [`PDB_OFF_W-1:0] off, input logic sgn, input logic [`PDB_WORD_W-1:0] w);
		logic [7:0] b;
		logic [15:0] h;
		b = w[{off, 3'h0} +: 8];
		h = off[1] ? w[31:16] : w[15:0];
		unique case (sz)
			pdb_pkg::PDB_SZ_BYTE: extract = {{24{sgn & b[7]}}, b};
			pdb_pkg::PDB_SZ_HALF: extract = {{16{sgn & h[15]}}, h};
			default: extract = w;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pdb_pkg::pdb_mode_e mode_r, mode_nxt;
	// Request holding slot
	logic q_valid_r, q_valid_nxt, q_write_r, q_xchg_r, q_xw_r, q_sgn_r, q_su_r;
	pdb_pkg::pdb_size_e q_size_r;
	logic [`PDB_WORD_W-1:0] q_addr_r, q_wdata_r;
	// Transfer in its address phase
	logic [`PDB_ADDR_W-1:0] a_addr_r;
	logic [`PDB_LANES-1:0] a_be_r;
	logic a_rw_r, a_su_r, a_lock_r, a_real_r, a_sgn_r;
	logic [`PDB_OFF_W-1:0] a_off_r;
	pdb_pkg::pdb_size_e a_size_r;
	logic [`PDB_WORD_W-1:0] a_wdata_r;
	// Transfer in its reply phase
	logic r_real_r, r_rw_r, r_ign_r, r_sgn_r;
	logic [`PDB_OFF_W-1:0] r_off_r;
	pdb_pkg::pdb_size_e r_size_r;
	logic [`PDB_WORD_W-1:0] r_addr_r, d_out_r;
	logic d_oe_r;

	logic counted, fault_now, succ_now, adv, accept, take, pop;

	// ----------------------------------------------------------------
	// Reply decode
	// ----------------------------------------------------------------
	always_comb begin
		counted = r_real_r && !r_ign_r;
		fault_now = counted && (bus.reply_code == pdb_pkg::PDB_RPL_FAULT);
		succ_now = counted && (bus.reply_code == pdb_pkg::PDB_RPL_SUCCESS);
		// Wait or no reply (PDB_RPL_NONE) on a counted transfer holds the pipeline
		adv = !counted || fault_now || succ_now;
		accept = req_valid_i && req_ready_o;
		take = adv && !fault_now && q_valid_r && (mode_r == pdb_pkg::PDB_MODE_RUN);
		pop = take && (!q_xchg_r || q_xw_r);
	end

	always_comb begin
		unique case (mode_r)
			pdb_pkg::PDB_MODE_RUN: mode_nxt = fault_now ? pdb_pkg::PDB_MODE_HALT : mode_r;
			pdb_pkg::PDB_MODE_HALT: mode_nxt = resume_i ? pdb_pkg::PDB_MODE_RUN : mode_r;
		endcase
		if (fault_now)
			q_valid_nxt = 1'b0;
		else if (accept)
			q_valid_nxt = 1'b1;
		else if (pop)
			q_valid_nxt = 1'b0;
		else
			q_valid_nxt = q_valid_r;
	end

	// ----------------------------------------------------------------
	// Mode and request slot
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_r <= pdb_pkg::PDB_MODE_RUN;
			q_valid_r <= 1'b0;
			req_ready_o <= 1'b0;
			halted_o <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			q_valid_r <= q_valid_nxt;
			req_ready_o <= !q_valid_nxt && (mode_nxt == pdb_pkg::PDB_MODE_RUN);
			halted_o <= (mode_nxt == pdb_pkg::PDB_MODE_HALT);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q_write_r <= 1'b0;
			q_xchg_r <= 1'b0;
			q_xw_r <= 1'b0;
			q_sgn_r <= 1'b0;
			q_su_r <= 1'b0;
			q_size_r <= pdb_pkg::PDB_SZ_WORD;
			q_addr_r <= `PDB_WORD_RST;
			q_wdata_r <= `PDB_WORD_RST;
		end else if (accept) begin
			q_write_r <= req_write_i;
			q_xchg_r <= req_xchg_i;
			q_xw_r <= 1'b0;
			q_sgn_r <= req_signed_i;
			q_su_r <= req_super_i;
			q_size_r <= req_size_i;
			q_addr_r <= req_addr_i;
			q_wdata_r <= req_wdata_i;
		end else if (take && q_xchg_r) begin
			q_xw_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Address phase
	// ----------------------------------------------------------------
	// Slot only moves once the previous reply is final, so a waited
	// transfer sees its successor's address repeated.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_addr_r <= `PDB_ADDR_RST;
			a_be_r <= `PDB_BE_NONE;
			a_rw_r <= 1'b1;
			a_su_r <= 1'b0;
			a_lock_r <= 1'b0;
			a_real_r <= 1'b0;
			a_sgn_r <= 1'b0;
			a_off_r <= 2'h0;
			a_size_r <= pdb_pkg::PDB_SZ_WORD;
			a_wdata_r <= `PDB_WORD_RST;
		end else if (take) begin
			a_addr_r <= q_addr_r[`PDB_WORD_W-1:`PDB_OFF_W];
			a_be_r <= lane_mask(q_size_r, q_addr_r[`PDB_OFF_W-1:0]);
			a_rw_r <= q_xchg_r ? !q_xw_r : !q_write_r;
			a_su_r <= q_su_r;
			a_lock_r <= q_xchg_r;
			a_real_r <= 1'b1;
			a_sgn_r <= q_sgn_r;
			a_off_r <= q_addr_r[`PDB_OFF_W-1:0];
			a_size_r <= q_size_r;
			a_wdata_r <= replicate(q_size_r, q_wdata_r);
		end else if (adv) begin
			// Null transfer keeps the last address and data
			a_be_r <= `PDB_BE_NONE;
			a_lock_r <= 1'b0;
			a_real_r <= 1'b0;
			a_rw_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Reply phase and write data
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_real_r <= 1'b0;
			r_rw_r <= 1'b1;
			r_ign_r <= 1'b0;
			r_sgn_r <= 1'b0;
			r_off_r <= 2'h0;
			r_size_r <= pdb_pkg::PDB_SZ_WORD;
			r_addr_r <= `PDB_WORD_RST;
			d_out_r <= `PDB_WORD_RST;
			d_oe_r <= 1'b0;
		end else if (adv) begin
			r_real_r <= a_real_r;
			r_rw_r <= a_rw_r;
			r_ign_r <= fault_now;
			r_sgn_r <= a_sgn_r;
			r_off_r <= a_off_r;
			r_size_r <= a_size_r;
			r_addr_r <= {a_addr_r, a_off_r};
			d_out_r <= a_wdata_r;
			// Enabled only after the prior reply was final
			d_oe_r <= a_real_r && !a_rw_r;
		end
		// Otherwise the write data stands for another reply phase
	end

	// ----------------------------------------------------------------
	// Completions
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o <= `PDB_WORD_RST;
			wr_done_o <= 1'b0;
			fault_o <= 1'b0;
			fault_addr_o <= `PDB_WORD_RST;
		end else begin
			rd_valid_o <= succ_now && r_rw_r;
			wr_done_o <= succ_now && !r_rw_r;
			fault_o <= fault_now;
			if (succ_now && r_rw_r)
				rd_data_o <= extract(r_size_r, r_off_r, r_sgn_r, bus.bidir_data_lines);
			if (fault_now)
				fault_addr_o <= r_addr_r;
		end
	end

	// ----------------------------------------------------------------
	// Bus drive
	// ----------------------------------------------------------------
	assign bus.word_address_lines = a_addr_r;
	assign bus.byte_lane_strobes = a_be_r;
	assign bus.privilege_select = a_su_r;
	assign bus.read_write_select = a_rw_r;
	assign bus.bus_lock = a_lock_r;
	assign bus.dev_data = d_out_r;
	assign bus.dev_data_oe = d_oe_r;

endmodule

`default_nettype wire

// [verilog/pdb_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdb_params.svh"

interface pdb_if;
	logic [`PDB_ADDR_W-1:0] word_address_lines;
	logic [`PDB_LANES-1:0] byte_lane_strobes;
	logic privilege_select;
	logic read_write_select;
	logic bus_lock;
	logic [`PDB_WORD_W-1:0] dev_data;
	logic dev_data_oe;
	logic [`PDB_WORD_W-1:0] rsp_data;
	logic rsp_data_oe;
	logic [`PDB_WORD_W-1:0] bidir_data_lines;
	pdb_pkg::pdb_reply_e reply_code;

	// Resolved data wire; the pipeline keeps the two enables apart
	assign bidir_data_lines = dev_data_oe ? dev_data : (rsp_data_oe ? rsp_data : `PDB_WORD_RST);

	modport dev (
		output word_address_lines, byte_lane_strobes, privilege_select, read_write_select,
		output bus_lock, dev_data, dev_data_oe,
		input bidir_data_lines, reply_code
	);

	modport rsp (
		input word_address_lines, byte_lane_strobes, privilege_select, read_write_select,
		input bus_lock, bidir_data_lines,
		output rsp_data, rsp_data_oe, reply_code
	);
endinterface

`default_nettype wire

// [verilog/pdb_params.svh]
`ifndef PDB_PARAMS_SVH
`define PDB_PARAMS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PDB_WORD_W 32
`define PDB_ADDR_W 30
`define PDB_LANES 4
`define PDB_LANE_W 8
`define PDB_OFF_W 2

// ----------------------------------------------------------------
// Responder store and wait counter
// ----------------------------------------------------------------
`define PDB_MEM_AW 4
`define PDB_MEM_DEPTH 16
`define PDB_WAIT_W 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDB_ADDR_RST 30'h0
`define PDB_WORD_RST 32'h0
`define PDB_BE_NONE 4'h0

`endif

// [verilog/pdb_pkg.sv]
package pdb_pkg;

	// Reply code driven by the responder during a reply phase
	typedef enum logic [1:0] {
		PDB_RPL_NONE = 2'h0,
		PDB_RPL_WAIT = 2'h1,
		PDB_RPL_SUCCESS = 2'h2,
		PDB_RPL_FAULT = 2'h3
	} pdb_reply_e;

	// Access size of a load or store
	typedef enum logic [1:0] {
		PDB_SZ_BYTE = 2'h0,
		PDB_SZ_HALF = 2'h1,
		PDB_SZ_WORD = 2'h2
	} pdb_size_e;

	// Issue mode of the device end
	typedef enum logic [1:0] {
		PDB_MODE_RUN = 2'b01,
		PDB_MODE_HALT = 2'b10
	} pdb_mode_e;

endpackage

// [verilog/pdb_rsp.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdb_params.svh"

module pdb_rsp (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Behaviour control
	input wire logic [`PDB_WAIT_W-1:0] wait_cycles_i,
	input wire logic fault_inject_i,
	// Status
	output logic lock_held_o,
	output logic wr_done_o,
	// Data bus
	pdb_if.rsp bus
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pdb_pkg::pdb_reply_e reply_r;
	logic [`PDB_WAIT_W-1:0] cnt_r;
	logic [`PDB_ADDR_W-1:0] j_addr_r;
	logic [`PDB_LANES-1:0] j_be_r;
	logic j_rw_r, skip_r, oe_r;
	logic [`PDB_WORD_W-1:0] d_out_r, rd_word;
	logic free, wr_en;
	logic [`PDB_MEM_AW-1:0] rd_idx;

	assign free = (reply_r != pdb_pkg::PDB_RPL_WAIT);
	assign rd_idx = free ? bus.word_address_lines[`PDB_MEM_AW-1:0] : j_addr_r[`PDB_MEM_AW-1:0];
	assign wr_en = (reply_r == pdb_pkg::PDB_RPL_SUCCESS) && !j_rw_r;

	// ----------------------------------------------------------------
	// Byte-lane store
	// ----------------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < `PDB_LANES; l++) begin : g_lane
			logic [`PDB_LANE_W-1:0] mem [`PDB_MEM_DEPTH];
			// Only strobed bytes are written, each from its own lane
			always_ff @(posedge mclk_i) begin
				if (wr_en && j_be_r[l])
					mem[j_addr_r[`PDB_MEM_AW-1:0]] <= bus.bidir_data_lines[l*8 +: 8];
			end
			// Whole word supplied on reads
			assign rd_word[l*8 +: 8] = mem[rd_idx];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Capture and reply
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reply_r <= pdb_pkg::PDB_RPL_NONE;
			cnt_r <= '0;
			j_addr_r <= `PDB_ADDR_RST;
			j_be_r <= `PDB_BE_NONE;
			j_rw_r <= 1'b1;
			skip_r <= 1'b0;
			oe_r <= 1'b0;
			d_out_r <= `PDB_WORD_RST;
		end else if (free) begin
			// Address and select latched only when the current reply is not a wait
			j_addr_r <= bus.word_address_lines;
			j_be_r <= bus.byte_lane_strobes;
			j_rw_r <= bus.read_write_select;
			skip_r <= 1'b0;
			oe_r <= 1'b0;
			if (bus.byte_lane_strobes == `PDB_BE_NONE || skip_r) begin
				reply_r <= pdb_pkg::PDB_RPL_NONE;
				j_be_r <= `PDB_BE_NONE;
			end else if (fault_inject_i) begin
				reply_r <= pdb_pkg::PDB_RPL_FAULT;
				skip_r <= 1'b1;
			end else if (wait_cycles_i != '0) begin
				reply_r <= pdb_pkg::PDB_RPL_WAIT;
				cnt_r <= wait_cycles_i - 1'b1;
			end else begin
				reply_r <= pdb_pkg::PDB_RPL_SUCCESS;
				oe_r <= bus.read_write_select;
				d_out_r <= rd_word;
			end
		end else if (cnt_r == '0) begin
			reply_r <= pdb_pkg::PDB_RPL_SUCCESS;
			oe_r <= j_rw_r;
			d_out_r <= rd_word;
		end else begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// Other masters are held off while this is high
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_held_o <= 1'b0;
			wr_done_o <= 1'b0;
		end else begin
			lock_held_o <= bus.bus_lock;
			wr_done_o <= wr_en;
		end
	end

	assign bus.reply_code = reply_r;
	assign bus.rsp_data = d_out_r;
	assign bus.rsp_data_oe = oe_r;

endmodule

`default_nettype wire
